/* File: bench/ssp_host_model.sv */
// Host model that drives the serial link and the load strobe
`timescale 1ns/1ps
`default_nettype none

module ssp_host_model (
  // Timing reference for the strobe
  input  wire logic clk,
  // Serial link toward the device
  output var  logic serial_clk,
  output var  logic serial_data,
  output var  logic load_strobe
);
  initial begin
    serial_clk  = 1'b0;
    serial_data = 1'b0;
    load_strobe = 1'b0;
  end

  // Word goes out MSB first; the link clock parks low between frames
  task automatic send(input logic [19:0] word, input logic strobe);
    for (int i = 19; i >= 0; i--) begin
      serial_data = word[i];
      #16 serial_clk = 1'b1;
      #16 serial_clk = 1'b0;
    end
    // Released line shows the inverse so a stale bit is never trusted
    #50 serial_data = ~word[0];
    if (strobe) begin
      @(negedge clk) load_strobe = 1'b1;
      repeat (4) @(negedge clk);
      load_strobe = 1'b0;
      repeat (4) @(negedge clk);
    end
  endtask : send
endmodule : ssp_host_model
`default_nettype wire

/* File: bench/synth_serial_program_latches_tb.sv */
// Self-checking testbench of the serial program latches
`timescale 1ns/1ps
`default_nettype none
`include "ssp_params.svh"

module synth_serial_program_latches_tb;
  import ssp_pkg::*;
  logic                    clk = 1'b0;
  logic                    reset = 1'b1;
  logic                    rx_pin = 1'b1;
  logic                    tx_pin = 1'b1;
  logic                    serial_clk, serial_data, load_strobe;
  ssp_div_s                div_cfg;
  logic [`SSP_F_W-1:0]     function_word;
  logic [`SSP_F_W-1:0]     ef = `SSP_F_RST;
  logic [`SSP_RATIO_W-1:0] feedback_ratio;
  logic                    rx_sleep, tx_sleep;
  logic [31:0]             seed = 32'hF538857D;
  logic [5:0]              ea;
  logic [6:0]              eb;
  logic [4:0]              er = 5'h00;
  int                      num_errors = 0;
  int                      total_checks = 0;
  int                      cycles = 0;

  ssp_host_model ssp_host_model_i (.clk(clk), .serial_clk(serial_clk),
    .serial_data(serial_data), .load_strobe(load_strobe));
  ssp_top ssp_top_i (.clk(clk), .reset(reset), .serial_clk(serial_clk),
    .serial_data(serial_data), .load_strobe(load_strobe), .rx_sleep_pin(rx_pin),
    .tx_sleep_pin(tx_pin), .div_cfg(div_cfg), .function_word(function_word),
    .feedback_ratio(feedback_ratio), .rx_sleep(rx_sleep), .tx_sleep(tx_sleep));

  // 40 MHz system clock
  always #12.5 clk = ~clk;

  // Hang guard, well above the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [12:0] ratio_exp(input logic [6:0] b, input logic [5:0] a,
                                            input logic p);
    return (p ? `SSP_PRESCALE_HI : `SSP_PRESCALE_LO) * b + 13'(a);
  endfunction : ratio_exp

  // Reserved method codes leave both chains awake
  function automatic logic sleep_exp(input logic [17:0] f, input logic pin, input int b);
    case ({f[`SSP_F_METHOD_B], f[`SSP_F_METHOD_A]})
      2'b00:   return f[b];
      2'b11:   return ~pin;
      default: return 1'b0;
    endcase
  endfunction : sleep_exp

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      num_errors++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check

  task automatic report_and_stop();
    if (num_errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // Random loads with boundary counts in the first passes
  initial begin
    repeat (20) @(posedge clk);
    @(negedge clk) reset = 1'b0;
    @(negedge clk);
    check(div_cfg, 0);
    check(function_word, 0);
    for (int n = 0; n < 40; n++) begin
      seed = lfsr(seed);
      ea = (n == 1) ? 6'h3F : ((n == 0) ? 6'h00 : seed[5:0]);
      eb = 7'(ea) + 7'(seed[11:6]);
      if (n < 2) eb = n ? 7'h7F : 7'h03;
      if (eb < 7'h03) eb = 7'h03;
      ssp_host_model_i.send({seed[31:27], eb, ea, 2'b00}, 1'b1);
      check(div_cfg, {eb, ea, er});
      check(feedback_ratio, ratio_exp(eb, ea, ef[0]));
      er = (n < 2) ? (n ? 5'h1F : 5'h03) : 5'h03 + 5'(seed[16:12] % 29);
      ssp_host_model_i.send({seed[31:19], er, 2'b10}, 1'b1);
      check(div_cfg, {eb, ea, er});
      seed = lfsr(seed);
      ef = seed[17:0];
      if (n < 4) ef[11:10] = 2'(n);
      @(negedge clk);
      rx_pin = seed[18];
      tx_pin = seed[19];
      ssp_host_model_i.send({ef, seed[20], 1'b1}, 1'b1);
      check(function_word, ef);
      check(feedback_ratio, ratio_exp(eb, ea, ef[0]));
      for (int k = 0; k < 2; k++) begin
        check(rx_sleep, sleep_exp(ef, rx_pin, `SSP_F_RX_SLEEP));
        check(tx_sleep, sleep_exp(ef, tx_pin, `SSP_F_TX_SLEEP));
        rx_pin = ~rx_pin;
        tx_pin = ~tx_pin;
        repeat (6) @(negedge clk);
      end
      ssp_host_model_i.send(seed[31:12], 1'b0);
      repeat (8) @(negedge clk);
      check(div_cfg, {eb, ea, er});
      check(function_word, ef);
    end
    report_and_stop();
  end
endmodule : synth_serial_program_latches_tb
`default_nettype wire

/* File: hw/ssp_params.svh */
// Field positions, widths and reset values of the serial program latches
`ifndef SSP_PARAMS_SVH
`define SSP_PARAMS_SVH
// Shift register and address bits
`define SSP_WORD_W       20
`define SSP_ADDR_LO      0
`define SSP_ADDR_HI      1
// Feedback divider word fields
`define SSP_A_LSB        2
`define SSP_A_W          6
`define SSP_B_LSB        8
`define SSP_B_W          7
// Reference divider word field
`define SSP_R_LSB        2
`define SSP_R_W          5
// Function word field and its bits (index 0 is function bit 1)
`define SSP_F_LSB        2
`define SSP_F_W          18
`define SSP_F_PRESCALE   0
`define SSP_F_RX_SLEEP   5
`define SSP_F_TX_SLEEP   6
`define SSP_F_METHOD_A   10
`define SSP_F_METHOD_B   11
// Total feedback ratio and prescaler moduli
`define SSP_RATIO_W      13
`define SSP_PRESCALE_LO  13'h0020
`define SSP_PRESCALE_HI  13'h0040
// Reset values
`define SSP_A_RST        6'h00
`define SSP_B_RST        7'h00
`define SSP_R_RST        5'h00
`define SSP_F_RST        18'h00000
`define SSP_RATIO_RST    13'h0000
`endif

/* File: hw/ssp_pkg.sv */
// Types shared by the serial program latch block
`include "ssp_params.svh"
package ssp_pkg;
  // Divider latches as one group
  typedef struct packed {
    logic [`SSP_B_W-1:0] prog_count;
    logic [`SSP_A_W-1:0] swallow_count;
    logic [`SSP_R_W-1:0] ref_count;
  } ssp_div_s;

  // Serial clock domain state
  typedef struct packed {
    logic [`SSP_WORD_W-1:0] shift;
  } ssp_link_s;

  // System clock domain state
  typedef struct packed {
    ssp_div_s                div;
    logic [`SSP_F_W-1:0]     fn;
    logic [`SSP_RATIO_W-1:0] ratio;
    logic                    rx_sleep;
    logic                    tx_sleep;
    logic                    ls_meta;
    logic                    ls_sync;
    logic                    ls_prev;
    logic                    rxp_meta;
    logic                    rxp_sync;
    logic                    txp_meta;
    logic                    txp_sync;
  } ssp_state_s;
endpackage : ssp_pkg

/* File: hw/ssp_top.sv */
// Serial program latches of the synthesizer: shift register, latches, sleep control
//
// Overview of operation
// - Data enters MSB first, one bit per serial clock rising edge, 20 bits.
// - On load strobe rising edge, payload goes to the latch the address picks.
// - Feedback divider is a 6-bit swallow and a 7-bit programmable count latch.
// - Address 00 at load strobe loads both feedback divider latches.
// - Feedback word: bits 7..2 swallow, 14..8 programmable, 19..15 ignored.
// - Address 10 loads bits 6..2 into the 5-bit reference latch.
// - Feedback ratio is prescaler times programmable plus swallow; prescaler 32 or 64.
// - Address bit 0 set loads bits 19..2 into the 18-bit function latch.
// - Function bits 11 and 12 choose software or pin power-down control.
// - Receive chain sleeps by its pin or function bit 6 per method.
// - Transmit chain sleeps by its pin or function bit 7 per method.
// - Bits 11,12 both zero mean software, both one mean pins; others reserved.
// - In software mode bit 6 or 7 high sleeps that chain, low wakes it.
`timescale 1ns/1ps
`default_nettype none
`include "ssp_params.svh"

module ssp_top (
  // System clock and reset
  input  wire  logic                    clk,
  input  wire  logic                    reset,
  // Serial link from the host
  input  wire  logic                    serial_clk,
  input  wire  logic                    serial_data,
  input  wire  logic                    load_strobe,
  // Hardware sleep pins
  input  wire  logic                    rx_sleep_pin,
  input  wire  logic                    tx_sleep_pin,
  // Latched settings
  output var   ssp_pkg::ssp_div_s       div_cfg,
  output logic [`SSP_F_W-1:0]           function_word,
  output logic [`SSP_RATIO_W-1:0]       feedback_ratio,
  // Chain sleep controls
  output logic                          rx_sleep,
  output logic                          tx_sleep
);
  import ssp_pkg::*;

  ssp_link_s  link_q;
  ssp_link_s  link_d;
  ssp_state_s s_q;
  ssp_state_s s_d;
  logic       load_edge;
  logic [1:0] method;

  // Serial clock domain: plain shift, no reset since it only carries data
  // Limitation: no handshake back, so a link edge near the strobe spoils the word
  always_comb begin
    link_d       = link_q;
    link_d.shift = {link_q.shift[`SSP_WORD_W-2:0], serial_data};
  end

  always_ff @(posedge serial_clk) begin
    link_q <= link_d;
  end

  // Strobe edge after the two-flop synchroniser
  assign load_edge = s_q.ls_sync & ~s_q.ls_prev;
  assign method    = {s_q.fn[`SSP_F_METHOD_B], s_q.fn[`SSP_F_METHOD_A]};

  // System clock domain next state
  always_comb begin
    s_d          = s_q;
    s_d.ls_meta  = load_strobe;
    s_d.ls_sync  = s_q.ls_meta;
    s_d.ls_prev  = s_q.ls_sync;
    s_d.rxp_meta = rx_sleep_pin;
    s_d.rxp_sync = s_q.rxp_meta;
    s_d.txp_meta = tx_sleep_pin;
    s_d.txp_sync = s_q.txp_meta;
    // The shift word is read only at the strobe edge: the host has parked
    // its clock by then, so the word is stable across the crossing.
    if (load_edge) begin
      if (link_q.shift[`SSP_ADDR_LO]) begin
        // Address bit 1 is a don't care here
        s_d.fn = link_q.shift[`SSP_F_LSB +: `SSP_F_W];
      end else if (link_q.shift[`SSP_ADDR_HI]) begin
        s_d.div.ref_count = link_q.shift[`SSP_R_LSB +: `SSP_R_W];
      end else begin
        // Bits above the programmable count are dropped
        s_d.div.swallow_count = link_q.shift[`SSP_A_LSB +: `SSP_A_W];
        s_d.div.prog_count    = link_q.shift[`SSP_B_LSB +: `SSP_B_W];
      end
    end
    // Total ratio; ranges are the host's to keep, no clamping done here
    s_d.ratio = (s_q.fn[`SSP_F_PRESCALE] ? `SSP_PRESCALE_HI : `SSP_PRESCALE_LO)
                * {6'h00, s_q.div.prog_count}
                + {7'h00, s_q.div.swallow_count};
    // Sleep method: reserved test codes leave both chains awake
    case (method)
      2'b00: begin
        s_d.rx_sleep = s_q.fn[`SSP_F_RX_SLEEP];
        s_d.tx_sleep = s_q.fn[`SSP_F_TX_SLEEP];
      end
      2'b11: begin
        s_d.rx_sleep = ~s_q.rxp_sync;
        s_d.tx_sleep = ~s_q.txp_sync;
      end
      default: begin
        s_d.rx_sleep = 1'b0;
        s_d.tx_sleep = 1'b0;
      end
    endcase
  end

  // Register the system state
  always_ff @(posedge clk) begin
    if (reset) begin
      s_q                   <= '0;
      s_q.div.swallow_count <= `SSP_A_RST;
      s_q.div.prog_count    <= `SSP_B_RST;
      s_q.div.ref_count     <= `SSP_R_RST;
      s_q.fn                <= `SSP_F_RST;
      s_q.ratio             <= `SSP_RATIO_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flops
  assign div_cfg        = s_q.div;
  assign function_word  = s_q.fn;
  assign feedback_ratio = s_q.ratio;
  assign rx_sleep       = s_q.rx_sleep;
  assign tx_sleep       = s_q.tx_sleep;

  // Feedback load takes both counts from the word
  property p_fb_load;
    @(posedge clk) disable iff (reset)
      load_edge && (link_q.shift[1:0] == 2'b00) |=>
        div_cfg.swallow_count == $past(link_q.shift[7:2]) &&
        div_cfg.prog_count == $past(link_q.shift[14:8]) &&
        $stable(function_word) && $stable(div_cfg.ref_count);
  endproperty
  a_fb_load: assert property (p_fb_load) else $error("feedback load wrong");

  // Reference load takes only its five bits
  property p_ref_load;
    @(posedge clk) disable iff (reset)
      load_edge && (link_q.shift[1:0] == 2'b10) |=>
        div_cfg.ref_count == $past(link_q.shift[6:2]) &&
        $stable(div_cfg.prog_count) && $stable(div_cfg.swallow_count) &&
        $stable(function_word);
  endproperty
  a_ref_load: assert property (p_ref_load) else $error("reference load wrong");

  // Function load for either value of address bit 1
  property p_fn_load;
    @(posedge clk) disable iff (reset)
      load_edge && link_q.shift[0] |=>
        function_word == $past(link_q.shift[19:2]) && $stable(div_cfg);
  endproperty
  a_fn_load: assert property (p_fn_load) else $error("function load wrong");

  // Divider and function latches hold without a strobe edge
  property p_hold;
    @(posedge clk) disable iff (reset)
      !load_edge |=> $stable(div_cfg) && $stable(function_word);
  endproperty
  a_hold: assert property (p_hold) else $error("latch changed without strobe");

  // Strobe rise gives a single load edge one clock after it enters the synchroniser
  property p_strobe;
    @(posedge clk) disable iff (reset)
      $rose(s_q.ls_meta) |-> ##1 load_edge ##1 !load_edge;
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe edge lost");

  // Ratio follows the latches one clock later
  property p_ratio;
    @(posedge clk) disable iff (reset)
      1'b1 |=> feedback_ratio ==
        ($past(function_word[0]) ? 13'h0040 : 13'h0020) * {6'h00, $past(div_cfg.prog_count)}
        + {7'h00, $past(div_cfg.swallow_count)};
  endproperty
  a_ratio: assert property (p_ratio) else $error("feedback ratio wrong");

  // Software method drives sleep from the function bits
  property p_sw_sleep;
    @(posedge clk) disable iff (reset)
      function_word[11:10] == 2'b00 |=>
        rx_sleep == $past(function_word[5]) && tx_sleep == $past(function_word[6]);
  endproperty
  a_sw_sleep: assert property (p_sw_sleep) else $error("software sleep wrong");

  // Pin method: a low pin sleeps the chain
  property p_hw_sleep;
    @(posedge clk) disable iff (reset)
      function_word[11:10] == 2'b11 |=>
        rx_sleep == !$past(s_q.rxp_sync) && tx_sleep == !$past(s_q.txp_sync);
  endproperty
  a_hw_sleep: assert property (p_hw_sleep) else $error("pin sleep wrong");

  // Reserved method codes keep both chains awake
  property p_rsv_sleep;
    @(posedge clk) disable iff (reset)
      function_word[11] != function_word[10] |=> !rx_sleep && !tx_sleep;
  endproperty
  a_rsv_sleep: assert property (p_rsv_sleep) else $error("reserved method slept");

  // Ratio moves only after a latch has moved
  property p_ratio_hold;
    @(posedge clk) disable iff (reset)
      $stable(div_cfg) && $stable(function_word) |=> $stable(feedback_ratio);
  endproperty
  a_ratio_hold: assert property (p_ratio_hold) else $error("ratio moved alone");

  // Software sleep outputs hold while the function word holds
  property p_sw_hold;
    @(posedge clk) disable iff (reset)
      function_word[11:10] == 2'b00 && $stable(function_word) |=>
        $stable(rx_sleep) && $stable(tx_sleep);
  endproperty
  a_sw_hold: assert property (p_sw_hold) else $error("software sleep moved alone");

  // Pin method: sleep outputs follow only the synchronised pins
  property p_hw_hold;
    @(posedge clk) disable iff (reset)
      function_word[11:10] == 2'b11 && $stable(function_word) &&
        $stable(s_q.rxp_sync) && $stable(s_q.txp_sync) |=>
        $stable(rx_sleep) && $stable(tx_sleep);
  endproperty
  a_hw_hold: assert property (p_hw_hold) else $error("pin sleep moved alone");
endmodule : ssp_top
`default_nettype wire
